// ### rtl/sat_consts.svh
// register indices, field positions and reset values of the address table access block
`ifndef SAT_CONSTS_SVH
`define SAT_CONSTS_SVH
`define SAT_CMD_IDX 14'h1800
`define SAT_WRL_IDX 14'h1801
`define SAT_WRH_IDX 14'h1802
`define SAT_RDL_IDX 14'h1803
`define SAT_RDH_IDX 14'h1804
`define SAT_STS_IDX 14'h1805
`define SAT_CMD_NEXT 0
`define SAT_CMD_FIRST 1
`define SAT_CMD_MAKE 2
`define SAT_STS_MAKE_PEND 0
`define SAT_STS_BUSY 1
`define SAT_HI_VALID 24
`define SAT_ENT_VALID 56
`define SAT_HI_MASK 32'h01FF_FFFF
`define SAT_RST_WORD 32'h0000_0000
`define SAT_TABLE_DEPTH 1024
`define SAT_RESP_OKAY 2'h0
`define SAT_RESP_SLVERR 2'h2
`define SAT_ADDR_W 16
`endif

// ### rtl/sat_pkg.sv
// types shared by the address table access block
package sat_pkg;
	typedef enum logic [1:0] {
		SAT_IDLE = 2'h0,
		SAT_MAKE = 2'h1,
		SAT_READ = 2'h2
	} sat_eng_state_t;
endpackage : sat_pkg

// ### rtl/sat_tbl_if.sv
// link between the register bank and the table engine
`timescale 1ns/1ps
interface sat_tbl_if;
	logic req_make;
	logic req_first;
	logic req_next;
	logic take;
	logic done;
	logic done_make;
	logic busy;
	logic [63:0] wr_entry;
	logic [31:0] rd_low;
	logic [31:0] rd_high;
	modport regs (output req_make, req_first, req_next, wr_entry,
		input take, done, done_make, busy, rd_low, rd_high);
	modport engine (input req_make, req_first, req_next, wr_entry,
		output take, done, done_make, busy, rd_low, rd_high);
endinterface : sat_tbl_if

// ### rtl/sat_engine.sv
// address lookup table storage with make, get-first and get-next walks
`timescale 1ns/1ps
`include "sat_consts.svh"
module sat_engine #(
	parameter int DEPTH = `SAT_TABLE_DEPTH
) (
	input wire logic aclk,
	input wire logic aresetn,
	sat_tbl_if.engine tbl
);
	localparam int IW = $clog2(DEPTH);
	typedef struct packed {
		sat_pkg::sat_eng_state_t state;
		logic [IW:0] idx;
		logic [IW:0] ptr;
		logic [DEPTH-1:0] valid;
		logic free;
		logic [IW-1:0] free_idx;
		logic [31:0] rd_low;
		logic [31:0] rd_high;
		logic done;
		logic done_make;
	} sat_eng_st_t;
	sat_eng_st_t st_r;
	sat_eng_st_t st_nxt;
	logic [63:0] mem [DEPTH];
	logic [63:0] cur;
	logic we;
	logic [IW-1:0] waddr;
	logic take;

	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		st_nxt.done_make = 1'b0;
		take = 1'b0;
		we = 1'b0;
		waddr = st_r.idx[IW-1:0];
		cur = mem[st_r.idx[IW-1:0]];
		case (st_r.state)
			sat_pkg::SAT_IDLE: begin
				st_nxt.idx = '0;
				if (tbl.req_make) begin
					take = 1'b1;
					st_nxt.state = sat_pkg::SAT_MAKE;
					st_nxt.free = 1'b0;
				end else if (tbl.req_first) begin
					take = 1'b1;
					st_nxt.state = sat_pkg::SAT_READ;
				end else if (tbl.req_next) begin
					take = 1'b1;
					st_nxt.state = sat_pkg::SAT_READ;
					st_nxt.idx = st_r.ptr;
				end
			end
			sat_pkg::SAT_MAKE: begin
				if (st_r.idx[IW]) begin
					// no match: new entry goes to the first free slot, dropped when full
					if (st_r.free && tbl.wr_entry[`SAT_ENT_VALID]) begin
						we = 1'b1;
						waddr = st_r.free_idx;
					end
					st_nxt.state = sat_pkg::SAT_IDLE;
					st_nxt.done = 1'b1;
					st_nxt.done_make = 1'b1;
				end else if (st_r.valid[st_r.idx[IW-1:0]] && cur[47:0] == tbl.wr_entry[47:0]) begin
					we = 1'b1;
					st_nxt.state = sat_pkg::SAT_IDLE;
					st_nxt.done = 1'b1;
					st_nxt.done_make = 1'b1;
				end else begin
					if (!st_r.valid[st_r.idx[IW-1:0]] && !st_r.free) begin
						st_nxt.free = 1'b1;
						st_nxt.free_idx = st_r.idx[IW-1:0];
					end
					st_nxt.idx = st_r.idx + 1'b1;
				end
			end
			sat_pkg::SAT_READ: begin
				if (st_r.idx[IW]) begin
					// end of table: an all-zero entry with valid clear
					st_nxt.rd_low = `SAT_RST_WORD;
					st_nxt.rd_high = `SAT_RST_WORD;
					st_nxt.ptr = st_r.idx;
					st_nxt.state = sat_pkg::SAT_IDLE;
					st_nxt.done = 1'b1;
				end else if (st_r.valid[st_r.idx[IW-1:0]]) begin
					st_nxt.rd_low = cur[31:0];
					st_nxt.rd_high = cur[63:32];
					st_nxt.ptr = st_r.idx + 1'b1;
					st_nxt.state = sat_pkg::SAT_IDLE;
					st_nxt.done = 1'b1;
				end else begin
					st_nxt.idx = st_r.idx + 1'b1;
				end
			end
			default: st_nxt.state = sat_pkg::SAT_IDLE;
		endcase
		if (we) begin
			st_nxt.valid[waddr] = tbl.wr_entry[`SAT_ENT_VALID];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= tbl.wr_entry;
		end
	end

	assign tbl.take = take;
	assign tbl.done = st_r.done;
	assign tbl.done_make = st_r.done_make;
	assign tbl.busy = st_r.state != sat_pkg::SAT_IDLE;
	assign tbl.rd_low = st_r.rd_low;
	assign tbl.rd_high = st_r.rd_high;

	default clocking eng_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	first_start_a: assert property (st_r.state == sat_pkg::SAT_IDLE && tbl.req_first && !tbl.req_make
		|=> st_r.state == sat_pkg::SAT_READ && st_r.idx == '0)
		else $error("get-first did not restart at table start");
	next_start_a: assert property (st_r.state == sat_pkg::SAT_IDLE && tbl.req_next && !tbl.req_make
		&& !tbl.req_first |=> st_r.state == sat_pkg::SAT_READ && st_r.idx == $past(st_r.ptr))
		else $error("get-next did not continue from read pointer");
	read_load_a: assert property (st_r.state == sat_pkg::SAT_READ && !st_r.idx[IW]
		&& st_r.valid[st_r.idx[IW-1:0]] |=> tbl.done && tbl.rd_low == $past(cur[31:0])
		&& tbl.rd_high == $past(cur[63:32]))
		else $error("valid entry not loaded into read data");
	entry_write_a: assert property (we |=> mem[$past(waddr)] == $past(tbl.wr_entry))
		else $error("table entry differs from write data");
	entry_valid_a: assert property (we |=> st_r.valid[$past(waddr)] == $past(tbl.wr_entry[`SAT_ENT_VALID]))
		else $error("entry valid flag not taken from write data");
endmodule : sat_engine

// ### rtl/sat_regs.sv
// AXI4-Lite register bank for manual access to the address lookup table
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "sat_consts.svh"
// What this block does
// - make-entry writes both write words into table
// - make-entry also changes or deletes existing entries
// - get-first restarts pointer, loads first valid entry
// - get-next loads next valid entry after pointer
// - writing zero to command bits does nothing
// - low write word holds first 32 MAC bits
// - high write word holds remaining entry fields
module sat_regs #(
	parameter int DEPTH = `SAT_TABLE_DEPTH
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`SAT_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [`SAT_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	typedef struct packed {
		logic aw_have;
		logic [`SAT_ADDR_W-1:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [2:0] cmd;
		logic [31:0] wr_low;
		logic [31:0] wr_high;
		logic [2:0] req;
		logic make_pend;
	} sat_reg_st_t;

	sat_reg_st_t st_r;
	sat_reg_st_t st_nxt;
	sat_tbl_if tbl ();
	logic wr_fire;
	logic [13:0] wr_idx;
	logic [13:0] rd_idx;
	logic [2:0] cmd_new;
	logic [31:0] cmd_word;
	logic [2:0] set;
	logic [2:0] clr;
	logic [31:0] status;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	sat_engine #(
		.DEPTH(DEPTH)
	) u_engine (
		.aclk(aclk),
		.aresetn(aresetn),
		.tbl(tbl)
	);

	assign tbl.req_make = st_r.req[`SAT_CMD_MAKE];
	assign tbl.req_first = st_r.req[`SAT_CMD_FIRST];
	assign tbl.req_next = st_r.req[`SAT_CMD_NEXT];
	assign tbl.wr_entry = {st_r.wr_high, st_r.wr_low};

	assign awready = !st_r.aw_have && !st_r.bvalid;
	assign wready = !st_r.w_have && !st_r.bvalid;
	assign arready = !st_r.rvalid;
	assign bvalid = st_r.bvalid;
	assign bresp = st_r.bresp;
	assign rvalid = st_r.rvalid;
	assign rdata = st_r.rdata;
	assign rresp = st_r.rresp;

	always_comb begin
		status = `SAT_RST_WORD;
		status[`SAT_STS_MAKE_PEND] = st_r.make_pend;
		status[`SAT_STS_BUSY] = tbl.busy || (|st_r.req);
	end

	always_comb begin
		st_nxt = st_r;
		wr_fire = st_r.aw_have && st_r.w_have && !st_r.bvalid;
		wr_idx = st_r.aw_addr[`SAT_ADDR_W-1:2];
		rd_idx = araddr[`SAT_ADDR_W-1:2];
		cmd_new = st_r.cmd;
		cmd_word = merge({29'h0, st_r.cmd}, st_r.w_data, st_r.w_strb);
		clr = 3'h0;
		// the engine takes requests in the order make, first, next
		if (tbl.take) begin
			if (st_r.req[`SAT_CMD_MAKE]) begin
				clr[`SAT_CMD_MAKE] = 1'b1;
			end else if (st_r.req[`SAT_CMD_FIRST]) begin
				clr[`SAT_CMD_FIRST] = 1'b1;
			end else begin
				clr[`SAT_CMD_NEXT] = 1'b1;
			end
		end
		if (awvalid && awready) begin
			st_nxt.aw_have = 1'b1;
			st_nxt.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			st_nxt.w_have = 1'b1;
			st_nxt.w_data = wdata;
			st_nxt.w_strb = wstrb;
		end
		if (st_r.bvalid && bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (wr_fire) begin
			st_nxt.aw_have = 1'b0;
			st_nxt.w_have = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = `SAT_RESP_OKAY;
			if (wr_idx == `SAT_CMD_IDX) begin
				cmd_new = cmd_word[2:0];
			end else if (wr_idx == `SAT_WRL_IDX) begin
				st_nxt.wr_low = merge(st_r.wr_low, st_r.w_data, st_r.w_strb);
			end else if (wr_idx == `SAT_WRH_IDX) begin
				st_nxt.wr_high = merge(st_r.wr_high, st_r.w_data, st_r.w_strb) & `SAT_HI_MASK;
			end else if (wr_idx != `SAT_RDL_IDX && wr_idx != `SAT_RDH_IDX && wr_idx != `SAT_STS_IDX) begin
				st_nxt.bresp = `SAT_RESP_SLVERR;
			end
		end
		st_nxt.cmd = cmd_new;
		// only a 0 to 1 change of a command bit starts an operation
		set = cmd_new & ~st_r.cmd;
		st_nxt.req = (st_r.req & ~clr) | set;
		st_nxt.make_pend = st_nxt.req[`SAT_CMD_MAKE] || (st_r.make_pend && !tbl.done_make);
		if (st_r.rvalid && rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = `SAT_RESP_OKAY;
			st_nxt.rdata = `SAT_RST_WORD;
			if (rd_idx == `SAT_CMD_IDX) begin
				st_nxt.rdata[2:0] = st_r.cmd;
			end else if (rd_idx == `SAT_WRL_IDX) begin
				st_nxt.rdata = st_r.wr_low;
			end else if (rd_idx == `SAT_WRH_IDX) begin
				st_nxt.rdata = st_r.wr_high;
			end else if (rd_idx == `SAT_RDL_IDX) begin
				st_nxt.rdata = tbl.rd_low;
			end else if (rd_idx == `SAT_RDH_IDX) begin
				st_nxt.rdata = tbl.rd_high;
			end else if (rd_idx == `SAT_STS_IDX) begin
				st_nxt.rdata = status;
			end else begin
				st_nxt.rresp = `SAT_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// helper logic for the checks below
	logic [31:0] pend_cnt;
	logic wl_full;
	assign wl_full = wr_fire && wr_idx == `SAT_WRL_IDX && st_r.w_strb == 4'hF;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_cnt <= 32'h0000_0000;
		end else if (st_r.make_pend) begin
			pend_cnt <= pend_cnt + 32'h0000_0001;
		end else begin
			pend_cnt <= 32'h0000_0000;
		end
	end

	default clocking reg_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	zero_no_op_a: assert property (((st_r.req & ~$past(st_r.req))
		& ~(st_r.cmd & ~$past(st_r.cmd))) == 3'h0)
		else $error("operation started without a command bit rising");
	make_set_a: assert property ($rose(st_r.cmd[`SAT_CMD_MAKE]) |-> st_r.make_pend
		&& st_r.req[`SAT_CMD_MAKE] ##1 (tbl.busy || st_r.req[`SAT_CMD_MAKE]))
		else $error("make-entry did not start a table write");
	make_hold_a: assert property (st_r.make_pend && !tbl.done_make |=> st_r.make_pend)
		else $error("make pending dropped before completion");
	make_clear_a: assert property ($fell(st_r.make_pend) |-> $past(tbl.done_make))
		else $error("make pending cleared without completion");
	make_bound_a: assert property (pend_cnt <= 2 * DEPTH + 8)
		else $error("make-entry did not finish in time");
	low_store_a: assert property (wl_full |=> st_r.wr_low == $past(st_r.w_data)
		&& tbl.wr_entry[31:0] == $past(st_r.w_data))
		else $error("low write word not stored as written");
	high_rsvd_a: assert property (wr_fire && wr_idx == `SAT_WRH_IDX |=> st_r.wr_high[31:25] == 7'h0
		&& st_r.wr_high[24:0] == ($past(merge(st_r.wr_high, st_r.w_data, st_r.w_strb)) & `SAT_HI_MASK))
		else $error("high write word not stored as written");
	get_done_a: assert property ($rose(st_r.req[`SAT_CMD_FIRST]) && !st_r.req[`SAT_CMD_MAKE] && !tbl.busy
		|-> ##[2:1000] tbl.done)
		else $error("get-first produced no result");
	make_take_a: assert property (st_r.req[`SAT_CMD_MAKE] && !tbl.busy
		|-> tbl.take)
		else $error("idle engine did not take make-entry");
	pend_set_a: assert property ($rose(st_r.req[`SAT_CMD_MAKE])
		|-> st_r.make_pend)
		else $error("make pending not raised by make-entry");
	zero_write_a: assert property (wr_fire && wr_idx == `SAT_CMD_IDX && st_r.w_strb[0]
		&& st_r.w_data[2:0] == 3'h0 |=> (st_r.req & ~$past(st_r.req)) == 3'h0)
		else $error("writing zero to the command started an operation");

	// bus channel checks
	aw_take_a: assert property (awvalid && awready
		|=> st_r.aw_have && st_r.aw_addr == $past(awaddr))
		else $error("write address not captured");
	w_take_a: assert property (wvalid && wready
		|=> st_r.w_have && st_r.w_data == $past(wdata) && st_r.w_strb == $past(wstrb))
		else $error("write data not captured");
	b_stand_a: assert property (st_r.bvalid && !bready
		|=> st_r.bvalid && $stable(st_r.bresp))
		else $error("write response dropped before it was taken");
	r_stand_a: assert property (st_r.rvalid && !rready
		|=> st_r.rvalid && $stable(st_r.rdata) && $stable(st_r.rresp))
		else $error("read response dropped before it was taken");
	w_answer_a: assert property (wr_fire
		|=> st_r.bvalid)
		else $error("complete write got no response");
	r_answer_a: assert property (arvalid && arready
		|=> st_r.rvalid)
		else $error("accepted read got no response");
	bad_write_a: assert property (wr_fire && wr_idx != `SAT_CMD_IDX && wr_idx != `SAT_WRL_IDX
		&& wr_idx != `SAT_WRH_IDX && wr_idx != `SAT_RDL_IDX && wr_idx != `SAT_RDH_IDX && wr_idx != `SAT_STS_IDX
		|=> st_r.bresp == `SAT_RESP_SLVERR && $stable(st_r.cmd) && $stable(st_r.wr_low)
		&& $stable(st_r.wr_high))
		else $error("unmapped write was not refused");
	bad_read_a: assert property (arvalid && arready && rd_idx != `SAT_CMD_IDX && rd_idx != `SAT_WRL_IDX
		&& rd_idx != `SAT_WRH_IDX && rd_idx != `SAT_RDL_IDX && rd_idx != `SAT_RDH_IDX && rd_idx != `SAT_STS_IDX
		|=> st_r.rresp == `SAT_RESP_SLVERR && st_r.rdata == `SAT_RST_WORD)
		else $error("unmapped read was not refused");

	// register contents
	ro_write_a: assert property (wr_fire && (wr_idx == `SAT_RDL_IDX || wr_idx == `SAT_RDH_IDX
		|| wr_idx == `SAT_STS_IDX) |=> st_r.bresp == `SAT_RESP_OKAY && $stable(st_r.cmd)
		&& $stable(st_r.wr_low) && $stable(st_r.wr_high))
		else $error("write to a read-only word had an effect");
	cmd_store_a: assert property (wr_fire && wr_idx == `SAT_CMD_IDX && st_r.w_strb[0]
		|=> st_r.cmd == $past(st_r.w_data[2:0]))
		else $error("command bits not stored as written");
	cmd_read_a: assert property (arvalid && arready && rd_idx == `SAT_CMD_IDX
		|=> st_r.rdata[31:3] == 29'h0 && st_r.rdata[2:0] == $past(st_r.cmd))
		else $error("command word not returned as held");
	status_read_a: assert property (arvalid && arready && rd_idx == `SAT_STS_IDX
		|=> st_r.rdata[`SAT_STS_MAKE_PEND] == $past(st_r.make_pend)
		&& st_r.rdata[`SAT_STS_BUSY] == $past(tbl.busy || (|st_r.req)))
		else $error("status word does not show the engine state");
	wrl_read_a: assert property (arvalid && arready && rd_idx == `SAT_WRL_IDX
		|=> st_r.rdata == $past(st_r.wr_low))
		else $error("low write word not returned as held");
	wrh_read_a: assert property (arvalid && arready && rd_idx == `SAT_WRH_IDX
		|=> st_r.rdata == $past(st_r.wr_high))
		else $error("high write word not returned as held");
	rdl_word_a: assert property (arvalid && arready && rd_idx == `SAT_RDL_IDX
		|=> st_r.rdata == $past(tbl.rd_low))
		else $error("low read word not returned as held");
	rdh_word_a: assert property (arvalid && arready && rd_idx == `SAT_RDH_IDX
		|=> st_r.rdata == $past(tbl.rd_high))
		else $error("high read word not returned as held");

	make_done_c: cover property ($fell(st_r.make_pend));
	first_hit_c: cover property (tbl.done && !tbl.done_make && tbl.rd_high[`SAT_HI_VALID]);
	next_end_c: cover property (tbl.done && !tbl.done_make && !tbl.rd_high[`SAT_HI_VALID]);
	bad_addr_c: cover property (st_r.bvalid && st_r.bresp == `SAT_RESP_SLVERR);
	next_walk_c: cover property ($rose(st_r.req[`SAT_CMD_NEXT]));
endmodule : sat_regs

// ### tb/tb.sv
// self-checking testbench for the address table register bank
`timescale 1ns/1ps
`include "sat_consts.svh"
module tb;
	localparam logic [15:0] A_CMD = {`SAT_CMD_IDX, 2'b00};
	localparam logic [15:0] A_WRL = {`SAT_WRL_IDX, 2'b00};
	localparam logic [15:0] A_WRH = {`SAT_WRH_IDX, 2'b00};
	localparam logic [15:0] A_RDL = {`SAT_RDL_IDX, 2'b00};
	localparam logic [15:0] A_RDH = {`SAT_RDH_IDX, 2'b00};
	localparam logic [15:0] A_STS = {`SAT_STS_IDX, 2'b00};
	localparam logic [15:0] A_BAD = 16'h7000;
	localparam logic [31:0] ZW = 32'h0000_0000;
	localparam logic [31:0] OW = 32'hFFFF_FFFF;
	localparam logic [1:0] OK = `SAT_RESP_OKAY;
	localparam logic [1:0] SE = `SAT_RESP_SLVERR;
	localparam logic [31:0] E1_LO = 32'h0000_0001;
	localparam logic [31:0] E1_HI = 32'h0142_1234;
	localparam logic [31:0] E1_MOD = 32'h0141_1234;
	localparam logic [31:0] E2_LO = 32'hDEAD_BEEE;
	localparam logic [31:0] E2_HI = 32'h0141_5678;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [15:0] awaddr = 16'h0000;
	logic [15:0] araddr = 16'h0000;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0;
	logic awready;
	logic wready;
	logic bvalid;
	logic arready;
	logic rvalid;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic [31:0] rdata;
	int n_errors = 0;
	int tests_run = 0;
	typedef struct {logic wr; logic [15:0] a; logic [31:0] d; logic [31:0] x; logic [1:0] r;} sat_row_t;
	sat_row_t rows [16] = '{
		'{1'b0, A_CMD, ZW, ZW, OK}, '{1'b0, A_WRL, ZW, ZW, OK}, '{1'b0, A_WRH, ZW, ZW, OK},
		'{1'b0, A_RDL, ZW, ZW, OK}, '{1'b0, A_RDH, ZW, ZW, OK}, '{1'b0, A_STS, ZW, ZW, OK},
		'{1'b1, A_WRL, 32'hA5A5_5A5A, ZW, OK}, '{1'b0, A_WRL, ZW, 32'hA5A5_5A5A, OK},
		'{1'b1, A_WRH, OW, ZW, OK}, '{1'b0, A_WRH, ZW, `SAT_HI_MASK, OK},
		'{1'b1, A_CMD, 32'hFFFF_FFF8, ZW, OK}, '{1'b0, A_CMD, ZW, ZW, OK},
		'{1'b1, A_RDL, OW, ZW, OK}, '{1'b0, A_RDL, ZW, ZW, OK},
		'{1'b1, A_BAD, OW, ZW, SE}, '{1'b0, A_BAD, ZW, ZW, SE}
	};

	sat_regs #(.DEPTH(16)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	always #5 aclk = ~aclk;

	task automatic give_verdict;
		if (n_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk32

	task automatic chk2(input logic [1:0] got, input logic [1:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t resp got=%h exp=%h", $time, got, exp);
		end
	endtask : chk2

	// each channel is sampled mid-cycle and released just after the edge that took it
	task automatic bus_write(input logic [15:0] a, input logic [31:0] d, output logic [1:0] resp);
		logic aw_hs;
		logic w_hs;
		logic b_hs;
		b_hs = 1'b0;
		resp = 2'h3;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b_hs) begin
			@(negedge aclk);
			aw_hs = awvalid && awready;
			w_hs = wvalid && wready;
			b_hs = bvalid && bready;
			resp = bresp;
			@(posedge aclk);
			if (aw_hs) awvalid <= 1'b0;
			if (w_hs) wvalid <= 1'b0;
			if (b_hs) bready <= 1'b0;
		end
	endtask : bus_write

	task automatic bus_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic ar_hs;
		logic r_hs;
		r_hs = 1'b0;
		d = OW;
		resp = 2'h3;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r_hs) begin
			@(negedge aclk);
			ar_hs = arvalid && arready;
			r_hs = rvalid && rready;
			d = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ar_hs) arvalid <= 1'b0;
			if (r_hs) rready <= 1'b0;
		end
	endtask : bus_read

	task automatic wait_idle;
		logic [1:0] r;
		logic [31:0] v;
		int n;
		v = OW;
		n = 0;
		while (v !== ZW && n < 60) begin
			bus_read(A_STS, v, r);
			n++;
		end
		chk32(v, ZW);
	endtask : wait_idle

	task automatic make_entry(input logic [31:0] lo, input logic [31:0] hi, input logic pend);
		logic [1:0] r;
		logic [31:0] v;
		bus_write(A_WRL, lo, r);
		bus_write(A_WRH, hi, r);
		bus_write(A_CMD, 32'h0000_0004, r);
		if (pend) begin
			bus_read(A_STS, v, r);
			chk32(v & 32'h0000_0001, 32'h0000_0001);
		end
		wait_idle();
		bus_write(A_CMD, ZW, r);
	endtask : make_entry

	// the clearing write lands before the read words are fetched, so a reload on it would show
	task automatic get_entry(input logic [31:0] cmd, input logic [31:0] lo, input logic [31:0] hi);
		logic [1:0] r;
		logic [31:0] v;
		bus_write(A_CMD, cmd, r);
		wait_idle();
		bus_write(A_CMD, ZW, r);
		bus_read(A_RDL, v, r);
		chk32(v, lo);
		bus_read(A_RDH, v, r);
		chk32(v, hi);
	endtask : get_entry

	initial begin
		logic [1:0] r;
		logic [31:0] v;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				bus_write(rows[i].a, rows[i].d, r);
			end else begin
				bus_read(rows[i].a, v, r);
				chk32(v, rows[i].x);
			end
			chk2(r, rows[i].r);
		end
		make_entry(E1_LO, E1_HI, 1'b1);
		make_entry(E2_LO, E2_HI, 1'b0);
		get_entry(32'h0000_0002, E1_LO, E1_HI);
		get_entry(32'h0000_0001, E2_LO, E2_HI);
		get_entry(32'h0000_0001, ZW, ZW);
		make_entry(E1_LO, E1_MOD, 1'b0);
		get_entry(32'h0000_0002, E1_LO, E1_MOD);
		make_entry(E1_LO, 32'h0000_1234, 1'b0);
		get_entry(32'h0000_0002, E2_LO, E2_HI);
		get_entry(32'h0000_0001, ZW, ZW);
		// a second reset in mid-run must empty the table and the low write word
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		bus_read(A_WRL, v, r);
		chk32(v, ZW);
		get_entry(32'h0000_0002, ZW, ZW);
		give_verdict();
	end

	initial begin
		#200_000;
		n_errors++;
		give_verdict();
	end
endmodule : tb
